// ### core/preset_arm_regs.vh
// Constants for the preset and trigger arm control block
`ifndef PRESET_ARM_REGS_VH
`define PRESET_ARM_REGS_VH

// Command codes on cmdCode
`define CMD_NONE        4'h0
`define CMD_PRESET      4'h1
`define CMD_RESET       4'h2
`define CMD_ARM         4'h3
`define CMD_ABORT       4'h4
`define CMD_CONT_SET    4'h5
`define CMD_VERSION     4'h6
`define CMD_TRIG_DONE   4'h7
`define CMD_SET_SOURCE  4'h8

// Preset argument codes on cmdArg
`define ARG_EMPTY       2'h0
`define ARG_FACTORY     2'h1

// Arming states
`define ST_IDLE         2'h0
`define ST_WAIT         2'h1
`define ST_MEASURE      2'h2

// Enumerated defaults
`define MTYPE_AVERAGE   2'h0
`define SRC_INSTANT     2'h3
`define EDGE_RISING     1'h1
`define GAMMA_SINGLE    1'h0

// Numeric defaults: power in 0.01 dBm, frequency in kHz, dB in 0.01 dB
`define DEF_FILTER_LEN  10'h004
`define DEF_STEP_DET    1'h1
`define DEF_LIM_LOW     16'hDCD8
`define DEF_LIM_UPP     16'h2328
`define DEF_CH_OFFSET   16'h0000
`define DEF_FREQ_KHZ    24'h00C350
`define DEF_GAMMA_MAG   16'h0000
`define DEF_GAMMA_PH    16'h0000
`define DEF_TRIG_COUNT  16'h0001

// Error code -213 as a signed 16-bit value
`define ERR_ARM_IGNORED 16'hFF2B

// Version string XXXX.Y as six ASCII characters
`define VER_DOT         8'h2E
`define ASCII_ZERO      8'h30

`endif

// ### core/version_string.v
// Builds the version answer from year and version digits
`timescale 1ns/1ps
`include "preset_arm_regs.vh"
module version_string
#(
	parameter [15:0] YEAR_BCD = 16'h1999,
	parameter [3:0]  VER_DIGIT = 4'h0
)
(
	output wire [47:0] verText
);
	// Four year digits, a period, one version digit
	assign verText = {`ASCII_ZERO | {4'h0, YEAR_BCD[15:12]},
		`ASCII_ZERO | {4'h0, YEAR_BCD[11:8]},
		`ASCII_ZERO | {4'h0, YEAR_BCD[7:4]},
		`ASCII_ZERO | {4'h0, YEAR_BCD[3:0]},
		`VER_DOT,
		`ASCII_ZERO | {4'h0, VER_DIGIT}};
endmodule

// ### core/arm_state_machine.v
// Idle / wait-for-trigger / measure arming state machine
`timescale 1ns/1ps
`include "preset_arm_regs.vh"
module arm_state_machine
(
	input  wire       clk,
	input  wire       rstn,
	input  wire       doArm,
	input  wire       doAbort,
	input  wire       goIdle,
	input  wire       goWait,
	input  wire       contArm,
	input  wire       instantSrc,
	input  wire       trigDone,
	output reg  [1:0] state_reg,
	output reg        armRefused
);
	reg [1:0] state_next;
	reg       refuse;

	always @*
	begin
		state_next = state_reg;
		refuse = 1'b0;
		if (goIdle)
			state_next = `ST_IDLE;
		else if (goWait)
			state_next = `ST_WAIT;
		else if (doAbort)
			// Continuous arming rearms at once instead of parking idle
			state_next = contArm ? `ST_WAIT : `ST_IDLE;
		else if (doArm)
		begin
			if (state_reg != `ST_IDLE || contArm)
				refuse = 1'b1;
			else
				state_next = instantSrc ? `ST_MEASURE : `ST_WAIT;
		end
		else
		begin
			case (state_reg)
			`ST_IDLE:
				if (contArm)
					state_next = `ST_WAIT;
			`ST_WAIT:
				if (instantSrc)
					state_next = `ST_MEASURE;
			`ST_MEASURE:
				if (trigDone)
					state_next = contArm ? `ST_WAIT : `ST_IDLE;
			default:
				state_next = `ST_IDLE;
			endcase
		end
	end

	always @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			state_reg <= `ST_IDLE;
			armRefused <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			armRefused <= refuse;
		end
	end
endmodule

// ### core/preset_arm_control.v
// Preset, version query and trigger arming control
`timescale 1ns/1ps
`include "preset_arm_regs.vh"
module preset_arm_control
#(
	parameter [15:0] YEAR_BCD  = 16'h1999,
	parameter [3:0]  VER_DIGIT = 4'h0
)
(
	input  wire        clk,
	input  wire        rstn,
	input  wire        cmdValid,
	input  wire [3:0]  cmdCode,
	input  wire [1:0]  cmdArg,
	input  wire        contArmIn,
	input  wire [1:0]  sourceIn,
	input  wire        tableSelIn,
	input  wire        tableEnIn,
	input  wire [15:0] tableOffsetIn,
	input  wire        tableLoad,
	output reg         cmdReady,
	output reg         continuousArm,
	output reg  [1:0]  armState,
	output reg         opPending,
	output reg         measureStart,
	output reg         errValid,
	output reg  [15:0] errCode,
	output reg         presetRejected,
	output reg         verValid,
	output reg  [47:0] verData,
	output reg  [1:0]  measType,
	output reg         avgEnable,
	output reg         avgAutoFilter,
	output reg  [9:0]  filterLength,
	output reg         stepDetect,
	output reg         limitEnable,
	output reg         limitAutoClear,
	output reg  [15:0] limitLower,
	output reg  [15:0] limitUpper,
	output reg         tableSelect,
	output reg         tableEnable,
	output reg  [15:0] tableOffset,
	output reg         chanOffsetEn,
	output reg  [15:0] chanOffset,
	output reg  [23:0] measFreqKhz,
	output reg         gammaTableEn,
	output reg         gammaPointEn,
	output reg         sparamEn,
	output reg  [15:0] gammaMag,
	output reg  [15:0] gammaPhase,
	output reg         uncertEn,
	output reg         uncertGammaType,
	output reg         trigEdge,
	output reg  [15:0] trigCount,
	output reg  [1:0]  trigSource,
	output reg         delayAuto,
	output reg         seqDelayAuto
);
	wire        isPreset;
	wire        isReset;
	wire        presetOk;
	wire        loadDefaults;
	wire        doArm;
	wire        doAbort;
	wire [1:0]  stateNow;
	wire        armRefused;
	wire [47:0] verText;

	assign isPreset = cmdValid && cmdCode == `CMD_PRESET;
	assign isReset  = cmdValid && cmdCode == `CMD_RESET;
	assign presetOk = isPreset &&
		(cmdArg == `ARG_EMPTY || cmdArg == `ARG_FACTORY);
	// Reset shares the default load; continuous arm and the arm state differ
	assign loadDefaults = presetOk || isReset;
	assign doArm   = cmdValid && cmdCode == `CMD_ARM;
	assign doAbort = cmdValid && cmdCode == `CMD_ABORT;

	arm_state_machine armFsm
	(
		.clk        (clk),
		.rstn       (rstn),
		.doArm      (doArm),
		.doAbort    (doAbort),
		.goIdle     (isReset),
		.goWait     (presetOk),
		.contArm    (continuousArm),
		.instantSrc (trigSource == `SRC_INSTANT),
		.trigDone   (cmdValid && cmdCode == `CMD_TRIG_DONE),
		.state_reg  (stateNow),
		.armRefused (armRefused)
	);

	version_string #(
		.YEAR_BCD  (YEAR_BCD),
		.VER_DIGIT (VER_DIGIT)
	) verGen
	(
		.verText (verText)
	);

	// Status and event outputs
	always @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			cmdReady <= 1'b0;
			armState <= `ST_IDLE;
			opPending <= 1'b0;
			measureStart <= 1'b0;
			errValid <= 1'b0;
			errCode <= 16'h0000;
			presetRejected <= 1'b0;
			verValid <= 1'b0;
			verData <= 48'h000000000000;
		end
		else
		begin
			// Never blocks: arming does not stall the command stream
			cmdReady <= 1'b1;
			armState <= stateNow;
			opPending <= stateNow != `ST_IDLE;
			measureStart <= stateNow == `ST_MEASURE &&
				armState != `ST_MEASURE;
			errValid <= armRefused;
			if (armRefused)
				errCode <= `ERR_ARM_IGNORED;
			presetRejected <= isPreset && !presetOk;
			verValid <= cmdValid && cmdCode == `CMD_VERSION;
			verData <= verText;
		end
	end

	// Continuous arming; power-up behaves as a preset, so it starts set
	always @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			continuousArm <= 1'b1;
		else if (isReset)
			continuousArm <= 1'b0;
		else if (presetOk)
			continuousArm <= 1'b1;
		else if (cmdValid && cmdCode == `CMD_CONT_SET)
			continuousArm <= contArmIn;
	end

	// Offset table is owned by its own load strobe only
	always @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			tableSelect <= 1'b0;
			tableEnable <= 1'b0;
			tableOffset <= 16'h0000;
		end
		else if (tableLoad)
		begin
			tableSelect <= tableSelIn;
			tableEnable <= tableEnIn;
			tableOffset <= tableOffsetIn;
		end
	end

	// Averaging settings
	always @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			measType <= `MTYPE_AVERAGE;
			avgEnable <= 1'b1;
			avgAutoFilter <= 1'b1;
			filterLength <= `DEF_FILTER_LEN;
			stepDetect <= `DEF_STEP_DET;
		end
		else if (loadDefaults)
		begin
			measType <= `MTYPE_AVERAGE;
			avgEnable <= 1'b1;
			avgAutoFilter <= 1'b1;
			filterLength <= `DEF_FILTER_LEN;
			stepDetect <= `DEF_STEP_DET;
		end
	end

	// Limit settings
	always @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			limitEnable <= 1'b0;
			limitAutoClear <= 1'b1;
			limitLower <= `DEF_LIM_LOW;
			limitUpper <= `DEF_LIM_UPP;
		end
		else if (loadDefaults)
		begin
			limitEnable <= 1'b0;
			limitAutoClear <= 1'b1;
			limitLower <= `DEF_LIM_LOW;
			limitUpper <= `DEF_LIM_UPP;
		end
	end

	// Channel offset and frequency
	always @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			chanOffsetEn <= 1'b0;
			chanOffset <= `DEF_CH_OFFSET;
			measFreqKhz <= `DEF_FREQ_KHZ;
		end
		else if (loadDefaults)
		begin
			chanOffsetEn <= 1'b0;
			chanOffset <= `DEF_CH_OFFSET;
			measFreqKhz <= `DEF_FREQ_KHZ;
		end
	end

	// Corrections and uncertainty
	always @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			gammaTableEn <= 1'b0;
			gammaPointEn <= 1'b0;
			sparamEn <= 1'b0;
			gammaMag <= `DEF_GAMMA_MAG;
			gammaPhase <= `DEF_GAMMA_PH;
			uncertEn <= 1'b0;
			uncertGammaType <= `GAMMA_SINGLE;
		end
		else if (loadDefaults)
		begin
			gammaTableEn <= 1'b0;
			gammaPointEn <= 1'b0;
			sparamEn <= 1'b0;
			gammaMag <= `DEF_GAMMA_MAG;
			gammaPhase <= `DEF_GAMMA_PH;
			uncertEn <= 1'b0;
			uncertGammaType <= `GAMMA_SINGLE;
		end
	end

	// Trigger source has its own command besides the default load
	// Abort touches only the state machine, never these settings,
	// so a later arm sees the same source as before the abort
	always @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			trigSource <= `SRC_INSTANT;
		else if (loadDefaults)
			trigSource <= `SRC_INSTANT;
		else if (cmdValid && cmdCode == `CMD_SET_SOURCE)
			trigSource <= sourceIn;
	end

	// Remaining trigger settings
	always @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			trigEdge <= `EDGE_RISING;
			trigCount <= `DEF_TRIG_COUNT;
			delayAuto <= 1'b1;
			seqDelayAuto <= 1'b1;
		end
		else if (loadDefaults)
		begin
			trigEdge <= `EDGE_RISING;
			trigCount <= `DEF_TRIG_COUNT;
			delayAuto <= 1'b1;
			seqDelayAuto <= 1'b1;
		end
	end
endmodule

// ### verification/preset_arm_control_props.sv
// Port assertions for the preset and arming control
`timescale 1ns/1ps
`include "preset_arm_regs.vh"
module preset_arm_control_props
(
	input wire        clk,
	input wire        rstn,
	input wire        cmdValid,
	input wire [3:0]  cmdCode,
	input wire [1:0]  cmdArg,
	input wire        tableLoad,
	input wire        cmdReady,
	input wire        continuousArm,
	input wire [1:0]  armState,
	input wire        opPending,
	input wire        measureStart,
	input wire        errValid,
	input wire [15:0] errCode,
	input wire        presetRejected,
	input wire        verValid,
	input wire [47:0] verData,
	input wire [15:0] tableOffset,
	input wire [1:0]  trigSource
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	wire isCmd = cmdValid;
	wire idle = armState == `ST_IDLE;
	sequence s_run;
		##2 armState == `ST_MEASURE && opPending && measureStart
		##1 !measureStart;
	endsequence
	sequence s_refuse;
		##2 errValid ##1 errCode == `ERR_ARM_IGNORED;
	endsequence
	chk_arm_runs: assert property (
		isCmd && cmdCode == `CMD_ARM && idle && !continuousArm
		&& trigSource == `SRC_INSTANT |-> s_run) else $error("arm stalled");
	chk_arm_refused: assert property (
		isCmd && cmdCode == `CMD_ARM && continuousArm |-> s_refuse)
		else $error("arm not refused");
	chk_abort_idle: assert property (
		isCmd && cmdCode == `CMD_ABORT && !continuousArm
		&& armState == `ST_WAIT && trigSource != `SRC_INSTANT
		|-> ##2 idle && !opPending) else $error("abort kept armed");
	chk_abort_cont: assert property (
		isCmd && cmdCode == `CMD_ABORT && continuousArm
		|=> ##1 !idle [*2]) else $error("abort went idle");
	chk_reset_idle: assert property (
		isCmd && cmdCode == `CMD_RESET
		|=> !continuousArm ##1 idle && !opPending) else $error("reset");
	chk_preset_wait: assert property (
		isCmd && cmdCode == `CMD_PRESET && cmdArg <= `ARG_FACTORY
		|=> continuousArm ##1 !idle) else $error("preset not armed");
	chk_reject_quiet: assert property (
		isCmd && cmdCode == `CMD_PRESET && cmdArg > `ARG_FACTORY
		|=> $stable(continuousArm) && $stable(trigSource) && presetRejected)
		else $error("bad preset");
	chk_table_kept: assert property (
		isCmd && (cmdCode == `CMD_PRESET || cmdCode == `CMD_RESET)
		&& !tableLoad |=> $stable(tableOffset)) else $error("table lost");
	chk_ver_answer: assert property (
		isCmd && cmdCode == `CMD_VERSION |=> verValid
		&& verData[15:8] == `VER_DOT) else $error("version");
	chk_pend_mirror: assert property (opPending == !idle)
		else $error("pending flag");
	chk_ready_high: assert property ($past(rstn) |-> cmdReady)
		else $error("ready low");
endmodule

// ### verification/host.sv
// Host model that sends one command per call
`timescale 1ns/1ps
module host
(
	input  wire       clk,
	output reg        cmdValid,
	output reg  [3:0] cmdCode,
	output reg  [1:0] cmdArg,
	output reg        contArmIn,
	output reg  [1:0] sourceIn
);
	initial
	begin
		cmdValid = 1'b0;
		{cmdCode, cmdArg, contArmIn, sourceIn} = 9'h000;
	end
	// Idle lines show the inverse, so a stale value never passes
	task send(input [3:0] c, input [1:0] a);
	begin
		@(posedge clk);
		cmdValid <= 1'b1;
		{cmdCode, cmdArg, contArmIn, sourceIn} <= {c, a, a[0], a};
		@(posedge clk);
		cmdValid <= 1'b0;
		{cmdCode, cmdArg, contArmIn, sourceIn} <= ~{c, a, a[0], a};
	end
	endtask
endmodule

// ### verification/testbench.sv
// Self-checking bench for the preset and arming control
`timescale 1ns/1ps
`include "preset_arm_regs.vh"
module testbench;
	localparam [15:0] YR = 16'h2024;
	localparam [3:0]  VD = 4'h7;
	localparam [47:0] VTXT = {`ASCII_ZERO + YR[15:12],
		`ASCII_ZERO + YR[11:8], `ASCII_ZERO + YR[7:4],
		`ASCII_ZERO + YR[3:0], `VER_DOT, `ASCII_ZERO + VD};
	reg         clk, rstn, tableSelIn, tableEnIn, tableLoad;
	reg  [15:0] tableOffsetIn;
	reg  [47:0] verSeen;
	reg  [7:0]  nStart, nErr, nVer, nRej, sS, sE, sV, sR;
	integer     errors, samples_checked, cyc, a;
	wire        cmdValid, contArmIn, cmdReady, continuousArm, opPending;
	wire        measureStart, errValid, presetRejected, verValid, trigEdge;
	wire        avgEnable, avgAutoFilter, stepDetect, limitEnable;
	wire        limitAutoClear, tableSelect, tableEnable, chanOffsetEn;
	wire        gammaTableEn, gammaPointEn, sparamEn, uncertEn;
	wire        uncertGammaType, delayAuto, seqDelayAuto;
	wire [1:0]  cmdArg, sourceIn, armState, measType, trigSource;
	wire [3:0]  cmdCode;
	wire [9:0]  filterLength;
	wire [15:0] errCode, limitLower, limitUpper, tableOffset, chanOffset;
	wire [15:0] gammaMag, gammaPhase, trigCount;
	wire [23:0] measFreqKhz;
	wire [47:0] verData;
	preset_arm_control #(.YEAR_BCD(YR), .VER_DIGIT(VD))
		preset_arm_control_i (.*);
	host host_i (.*);
	task chk(input string what, input [63:0] exp, input [63:0] got);
	begin
		samples_checked = samples_checked + 1;
		if (got !== exp)
		begin
			errors = errors + 1;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	end
	endtask
	task tally_and_finish;
	begin
		$display("checks %0d mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	end
	endtask
	task tick(input integer n);
		repeat (n) @(negedge clk);
	endtask
	task check_defaults;
	begin
		chk("avg",
			{`MTYPE_AVERAGE, 2'b11, `DEF_FILTER_LEN, `DEF_STEP_DET},
			{measType, avgEnable, avgAutoFilter, filterLength, stepDetect});
		chk("limit", {2'b01, `DEF_LIM_LOW, `DEF_LIM_UPP},
			{limitEnable, limitAutoClear, limitLower, limitUpper});
		chk("chan", {1'b0, `DEF_CH_OFFSET, `DEF_FREQ_KHZ},
			{chanOffsetEn, chanOffset, measFreqKhz});
		chk("gamma", {3'b000, `DEF_GAMMA_MAG, `DEF_GAMMA_PH},
			{gammaTableEn, gammaPointEn, sparamEn, gammaMag, gammaPhase});
		chk("unc", {1'b0, `GAMMA_SINGLE}, {uncertEn, uncertGammaType});
		chk("edge", `EDGE_RISING, trigEdge);
		chk("trig", {`DEF_TRIG_COUNT, `SRC_INSTANT},
			{trigCount, trigSource});
		chk("delay", 2'b11, {delayAuto, seqDelayAuto});
	end
	endtask
	task t_power;
	begin
		tick(6);
		chk("up", {2'b11, `ST_MEASURE},
			{continuousArm, opPending, armState});
		chk("ready", 1'b1, cmdReady);
		check_defaults;
		$display("power-up test done");
	end
	endtask
	task t_preset;
	begin
		@(posedge clk);
		{tableSelIn, tableEnIn, tableOffsetIn, tableLoad} <= 19'h34B87;
		@(posedge clk);
		{tableSelIn, tableEnIn, tableOffsetIn, tableLoad} <= 19'h0B478;
		for (a = 3; a >= 0; a = a - 1)
		begin
			sR = nRej;
			host_i.send(`CMD_SET_SOURCE, 2'h0);
			host_i.send(`CMD_RESET, `ARG_EMPTY);
			tick(3);
			chk("reset", 4'h0, {continuousArm, opPending, armState});
			check_defaults;
			host_i.send(`CMD_SET_SOURCE, 2'h0);
			host_i.send(`CMD_PRESET, a[1:0]);
			tick(3);
			chk("table", 18'h1A5C3,
				{tableSelect, tableEnable, tableOffset});
			if (a > 1)
				chk("reject", {sR + 8'h01, 3'h0},
					{nRej, continuousArm, trigSource});
			else
			begin
				chk("preset", 2'b11, {continuousArm, opPending});
				check_defaults;
			end
		end
		$display("preset test done");
	end
	endtask
	task t_arm;
	begin
		host_i.send(`CMD_RESET, `ARG_EMPTY);
		{sS, sV, sE} = {nStart, nVer, nErr};
		host_i.send(`CMD_ARM, 2'h0);
		host_i.send(`CMD_VERSION, 2'h0);
		tick(4);
		chk("run", {`ST_MEASURE, 1'b1, sS + 8'h01},
			{armState, opPending, nStart});
		chk("ver", {sV + 8'h01, VTXT}, {nVer, verSeen});
		host_i.send(`CMD_ARM, 2'h0);
		tick(3);
		chk("err", {sE + 8'h01, `ERR_ARM_IGNORED}, {nErr, errCode});
		host_i.send(`CMD_TRIG_DONE, 2'h0);
		tick(3);
		chk("done", 3'h0, {armState, opPending});
		$display("arm test done");
	end
	endtask
	task t_abort;
	begin
		host_i.send(`CMD_SET_SOURCE, 2'h0);
		host_i.send(`CMD_ARM, 2'h0);
		tick(3);
		chk("wait", `ST_WAIT, armState);
		host_i.send(`CMD_ABORT, 2'h0);
		tick(3);
		chk("abort", 4'h0, {armState, trigSource});
		host_i.send(`CMD_ARM, 2'h0);
		tick(3);
		chk("rearm", `ST_WAIT, armState);
		host_i.send(`CMD_CONT_SET, 2'h1);
		host_i.send(`CMD_ABORT, 2'h0);
		tick(3);
		chk("cont", `ST_WAIT, armState);
		sE = nErr;
		host_i.send(`CMD_ARM, 2'h0);
		tick(3);
		chk("errs", sE + 8'h01, nErr);
		$display("abort test done");
	end
	endtask
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// Pulses are counted so a doubled or missing pulse shows up
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		{nStart, nErr} <= {nStart + measureStart, nErr + errValid};
		{nVer, nRej} <= {nVer + verValid, nRej + presetRejected};
		if (verValid)
			verSeen <= verData;
		if (cyc == 2000)
		begin
			errors = errors + 1;
			tally_and_finish;
		end
	end
	initial
	begin
		rstn = 1'b0;
		{tableSelIn, tableEnIn, tableOffsetIn, tableLoad} = 19'h0;
		{nStart, nErr, nVer, nRej, verSeen} = 80'h0;
		{errors, samples_checked, cyc} = 96'h0;
		repeat (8) @(posedge clk);
		rstn <= 1'b1;
		t_power;
		t_preset;
		t_arm;
		t_abort;
		tally_and_finish;
	end
endmodule
bind preset_arm_control preset_arm_control_props props_i (.clk, .rstn,
	.cmdValid, .cmdCode, .cmdArg, .tableLoad, .cmdReady, .continuousArm,
	.armState, .opPending, .measureStart, .errValid, .errCode,
	.presetRejected, .verValid, .verData, .tableOffset, .trigSource);
